// file: cpu_register_file_ctl_map.sv
// register storage: general-purpose sets and control register space
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Notes on behaviour
// - thirty-two 32-bit general registers, 5-bit index.
// - index 0 reads zero; writes to it are dropped.
// - index 31 holds return address, written by calls, read by return.
// - index 25 only for debug; breakpoint temp in set 0, reserved in shadows.
// - index 30 is break return in set 0, saved status in shadow sets.
// - shadow register sets are an optional build choice.
// - control registers reached only by control read/write in supervisor mode.
// - control space has 32 entries; 6 and 16 to 31 reserved.
// - entries 3 and 4 exist only without external interrupt interface.
// - entries 8 to 10 exist only with memory management unit.
// - entry 11 exists only with error correction built.
// - entries 13 to 15 exist only with protection unit built.
// - protection unit is disabled after reset.
// - protection unit toggled only by software write to enable bit.
// ----------------------------------------------------------------
module cpu_register_file_ctl_map
#(
    parameter bit HAS_SHADOW = 1'b1,
    parameter bit HAS_EXT_IRQ = 1'b0,
    parameter bit HAS_MMU = 1'b1,
    parameter bit HAS_ECC = 1'b1,
    parameter bit HAS_MPU = 1'b1,
    parameter logic [31:0] CPU_ID_VALUE = 32'h0000_0001 // arbitrary value
)(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // general read ports
    input wire logic [regfile_pkg::SET_W-1:0] rd_set_in,
    input wire logic [regfile_pkg::GPR_IDX_W-1:0] rd_a_idx_in,
    input wire logic [regfile_pkg::GPR_IDX_W-1:0] rd_b_idx_in,
    output logic [regfile_pkg::DATA_W-1:0] rd_a_data_out,
    output logic [regfile_pkg::DATA_W-1:0] rd_b_data_out,
    // general write port
    input wire logic wr_en_in,
    input wire logic [regfile_pkg::SET_W-1:0] wr_set_in,
    input wire logic [regfile_pkg::GPR_IDX_W-1:0] wr_idx_in,
    input wire logic [regfile_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_from_debug_in,
    // control register access
    input wire logic supervisor_mode_in,
    input wire logic ctl_rd_en_in,
    input wire logic ctl_wr_en_in,
    input wire logic [regfile_pkg::CTL_IDX_W-1:0] ctl_idx_in,
    input wire logic [regfile_pkg::DATA_W-1:0] ctl_wr_data_in,
    output logic [regfile_pkg::DATA_W-1:0] ctl_rd_data_out,
    output logic ctl_rd_valid_out,
    // hardware-updated control inputs
    input wire logic [regfile_pkg::DATA_W-1:0] irq_pending_in,
    input wire logic [regfile_pkg::DATA_W-1:0] exception_cause_in,
    input wire logic [regfile_pkg::DATA_W-1:0] faulting_address_in,
    // state outputs
    output logic mpu_enable_out,
    output logic [regfile_pkg::SET_W-1:0] current_set_out
);
    import regfile_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_SETS*32-1:0][DATA_W-1:0] gpr;
        logic [15:0][DATA_W-1:0] ctl;
        logic [DATA_W-1:0] rd_a;
        logic [DATA_W-1:0] rd_b;
        logic [DATA_W-1:0] ctl_rd;
        logic ctl_vld;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    logic [15:0] ctl_present;
    logic [SET_W-1:0] wr_set_eff;
    logic [SET_W-1:0] rd_set_eff;
    logic gpr_wr_ok;
    logic ctl_in_range;
    logic ctl_read_only;
    logic ctl_wr_ok;
    logic ctl_rd_ok;

    // ----------------------------------------------------------------
    // presence of control entries
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_present
            if (g == 6)
            begin : g_rsvd
                assign ctl_present[g] = 1'b0;
            end
            else if (g == 3 || g == 4)
            begin : g_irq
                assign ctl_present[g] = !HAS_EXT_IRQ;
            end
            else if (g >= 8 && g <= 10)
            begin : g_mmu
                assign ctl_present[g] = HAS_MMU;
            end
            else if (g == 11)
            begin : g_ecc
                assign ctl_present[g] = HAS_ECC;
            end
            else if (g >= 13)
            begin : g_mpu
                assign ctl_present[g] = HAS_MPU;
            end
            else
            begin : g_base
                assign ctl_present[g] = 1'b1;
            end
        end
    endgenerate

    assign wr_set_eff = HAS_SHADOW ? wr_set_in : '0;
    assign rd_set_eff = HAS_SHADOW ? rd_set_in : '0;

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    always_comb
    begin
        gpr_wr_ok = 1'b0;
        if (wr_en_in && wr_idx_in != ZERO_REG_IDX)
        begin
            if (wr_idx_in != BREAKPOINT_TEMP_IDX)
            begin
                gpr_wr_ok = 1'b1;
            end
            else if (wr_from_debug_in)
            begin
                gpr_wr_ok = 1'b1;
            end
        end
    end

    always_comb
    begin
        ctl_in_range = !ctl_idx_in[4] && ctl_present[ctl_idx_in[3:0]];
        // hardware-owned entries refuse writes
        if (ctl_idx_in == CTL_IRQ_PENDING_BITS)
        begin
            ctl_read_only = 1'b1;
        end
        else if (ctl_idx_in == CTL_PROCESSOR_IDENTIFIER)
        begin
            ctl_read_only = 1'b1;
        end
        else if (ctl_idx_in == CTL_EXCEPTION_CAUSE)
        begin
            ctl_read_only = 1'b1;
        end
        else if (ctl_idx_in == CTL_FAULTING_ADDRESS)
        begin
            ctl_read_only = 1'b1;
        end
        else
        begin
            ctl_read_only = 1'b0;
        end
    end

    assign ctl_wr_ok = ctl_wr_en_in && supervisor_mode_in && ctl_in_range && !ctl_read_only;
    assign ctl_rd_ok = ctl_rd_en_in && supervisor_mode_in && ctl_in_range;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.rd_a = (rd_a_idx_in == ZERO_REG_IDX) ? ZERO_WORD
                       : state_ff.gpr[{rd_set_eff, rd_a_idx_in}];
        nxt_state.rd_b = (rd_b_idx_in == ZERO_REG_IDX) ? ZERO_WORD
                       : state_ff.gpr[{rd_set_eff, rd_b_idx_in}];
        if (gpr_wr_ok)
        begin
            nxt_state.gpr[{wr_set_eff, wr_idx_in}] = wr_data_in;
        end
        // hardware-updated read-only entries
        nxt_state.ctl[CTL_IRQ_PENDING_BITS[3:0]] = irq_pending_in;
        nxt_state.ctl[CTL_EXCEPTION_CAUSE[3:0]] = exception_cause_in;
        nxt_state.ctl[CTL_FAULTING_ADDRESS[3:0]] = faulting_address_in;
        nxt_state.ctl[CTL_PROCESSOR_IDENTIFIER[3:0]] = CPU_ID_VALUE;
        if (ctl_wr_ok)
        begin
            nxt_state.ctl[ctl_idx_in[3:0]] = ctl_wr_data_in;
        end
        nxt_state.ctl_vld = ctl_rd_en_in && supervisor_mode_in;
        if (ctl_rd_ok)
        begin
            nxt_state.ctl_rd = state_ff.ctl[ctl_idx_in[3:0]];
        end
        else
        begin
            nxt_state.ctl_rd = ZERO_WORD;
        end
        // absent entries never hold data
        for (int i = 0; i < 16; i++)
        begin
            if (!ctl_present[i])
            begin
                nxt_state.ctl[i] = ZERO_WORD;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            state_ff.ctl <= '0;
            state_ff.ctl[CTL_PROCESSOR_IDENTIFIER[3:0]] <= CPU_ID_VALUE;
            state_ff.rd_a <= ZERO_WORD;
            state_ff.rd_b <= ZERO_WORD;
            state_ff.ctl_rd <= ZERO_WORD;
            state_ff.ctl_vld <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rd_a_data_out = state_ff.rd_a;
    assign rd_b_data_out = state_ff.rd_b;
    assign ctl_rd_data_out = state_ff.ctl_rd;
    assign ctl_rd_valid_out = state_ff.ctl_vld;
    assign mpu_enable_out = state_ff.ctl[CTL_CORE_CONFIGURATION[3:0]][CONFIG_MPU_ENABLE_BIT];
    assign current_set_out = HAS_SHADOW ?
        state_ff.ctl[CTL_PROCESSOR_STATUS[3:0]][STATUS_CRS_LSB +: SET_W] : '0;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_zero_reg_read: assert property (
        (rd_a_idx_in == ZERO_REG_IDX) |=> (rd_a_data_out == ZERO_WORD))
        else $error("zero register read nonzero");
    a_read_port_b: assert property (
        (rd_b_idx_in == ZERO_REG_IDX) |=> (rd_b_data_out == ZERO_WORD))
        else $error("port b zero read nonzero");
    a_write_readback: assert property (
        (wr_en_in && wr_idx_in != ZERO_REG_IDX && wr_idx_in != BREAKPOINT_TEMP_IDX
         && rd_a_idx_in == wr_idx_in && rd_set_eff == wr_set_eff) ##1
        (rd_a_idx_in == $past(wr_idx_in) && rd_set_eff == $past(wr_set_eff) && !wr_en_in)
        |=> (rd_a_data_out == $past(wr_data_in, 2)))
        else $error("written value not read back");
    a_user_no_ctl: assert property (
        (ctl_rd_en_in && !supervisor_mode_in) |=> !ctl_rd_valid_out)
        else $error("control read outside supervisor");
    a_rsvd_read_zero: assert property (
        (ctl_rd_en_in && ctl_idx_in >= CTL_RESERVED_UPPER) |=> (ctl_rd_data_out == ZERO_WORD))
        else $error("reserved entry read nonzero");
    a_six_read_zero: assert property (
        (ctl_rd_en_in && ctl_idx_in == CTL_RESERVED_SIX) |=> (ctl_rd_data_out == ZERO_WORD))
        else $error("entry six read nonzero");
    a_mpu_hold: assert property (
        !(ctl_wr_en_in && supervisor_mode_in && ctl_idx_in == CTL_CORE_CONFIGURATION)
        |=> $stable(mpu_enable_out))
        else $error("protection enable changed without write");
    a_mpu_reset_off: assert property (
        @(posedge mclk_in) disable iff (1'b0) $rose(rst_n_in) |-> !mpu_enable_out)
        else $error("protection enabled after reset");

    a_ctl_read_valid: assert property (
        (ctl_rd_en_in && supervisor_mode_in) |=> ctl_rd_valid_out)
        else $error("supervisor read without valid");
    a_user_read_zero: assert property (
        (ctl_rd_en_in && !supervisor_mode_in) |=> (ctl_rd_data_out == ZERO_WORD))
        else $error("user read returned data");
    a_idle_read_zero: assert property (
        !ctl_rd_en_in |=> (ctl_rd_data_out == ZERO_WORD))
        else $error("read data without request");
    a_user_no_write: assert property (
        !supervisor_mode_in |=> $stable(mpu_enable_out))
        else $error("protection enable changed in user mode");
    a_mpu_write_on: assert property (
        (ctl_wr_en_in && supervisor_mode_in && HAS_MPU &&
         ctl_idx_in == CTL_CORE_CONFIGURATION)
        |=> (mpu_enable_out == $past(ctl_wr_data_in[CONFIG_MPU_ENABLE_BIT])))
        else $error("protection enable not written");
    a_debug_reg_guard: assert property (
        (wr_en_in && wr_idx_in == BREAKPOINT_TEMP_IDX && !wr_from_debug_in)
        |=> (state_ff.gpr[{$past(wr_set_eff), BREAKPOINT_TEMP_IDX}]
             == $past(state_ff.gpr[{wr_set_eff, BREAKPOINT_TEMP_IDX}])))
        else $error("debug register written outside debug");
    a_ret_addr_write: assert property (
        (wr_en_in && wr_idx_in == RETURN_ADDRESS_IDX)
        |=> (state_ff.gpr[{$past(wr_set_eff), RETURN_ADDRESS_IDX}] == $past(wr_data_in)))
        else $error("return address not stored");
    a_shadow_status: assert property (
        (wr_en_in && wr_idx_in == SHADOW_STATUS_IDX)
        |=> (state_ff.gpr[{$past(wr_set_eff), SHADOW_STATUS_IDX}] == $past(wr_data_in)))
        else $error("index thirty not stored");
    a_pending_follow: assert property (
        !HAS_EXT_IRQ |=> (state_ff.ctl[CTL_IRQ_PENDING_BITS[3:0]] == $past(irq_pending_in)))
        else $error("pending entry does not follow input");
    a_read_port_data: assert property (
        (rd_b_idx_in != ZERO_REG_IDX)
        |=> (rd_b_data_out == $past(state_ff.gpr[{rd_set_eff, rd_b_idx_in}])))
        else $error("port b read wrong word");
    a_ident_read: assert property (
        (ctl_rd_en_in && supervisor_mode_in && ctl_idx_in == CTL_PROCESSOR_IDENTIFIER)
        |=> (ctl_rd_data_out == CPU_ID_VALUE))
        else $error("identifier entry wrong");
    a_absent_read_zero: assert property (
        (ctl_rd_en_in && !ctl_in_range) |=> (ctl_rd_data_out == ZERO_WORD))
        else $error("absent entry read nonzero");

    // ----------------------------------------------------------------
    // covers
    // ----------------------------------------------------------------
    c_ctl_read: cover property (ctl_rd_en_in && supervisor_mode_in ##1 ctl_rd_valid_out);
    c_mpu_on: cover property ($rose(mpu_enable_out));
    c_shadow_write: cover property (wr_en_in && wr_set_eff != '0);
    c_reserved_write: cover property (ctl_wr_en_in && supervisor_mode_in && ctl_idx_in[4]);
endmodule

// file: regfile_pkg.sv
// constants shared by the processor register storage
package regfile_pkg;
    localparam int DATA_W = 32;
    localparam int GPR_IDX_W = 5;
    localparam int CTL_IDX_W = 5;
    localparam int NUM_SETS = 2;
    localparam int SET_W = 1;
    // general-purpose register roles
    localparam logic [4:0] ZERO_REG_IDX = 5'h00;
    localparam logic [4:0] BREAKPOINT_TEMP_IDX = 5'h19;
    localparam logic [4:0] SHADOW_STATUS_IDX = 5'h1e;
    localparam logic [4:0] RETURN_ADDRESS_IDX = 5'h1f;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // control register offsets
    localparam logic [4:0] CTL_PROCESSOR_STATUS = 5'h00;
    localparam logic [4:0] CTL_SAVED_EXCEPTION_STATE = 5'h01;
    localparam logic [4:0] CTL_SAVED_BREAK_STATE = 5'h02;
    localparam logic [4:0] CTL_IRQ_ENABLE_MASK = 5'h03;
    localparam logic [4:0] CTL_IRQ_PENDING_BITS = 5'h04;
    localparam logic [4:0] CTL_PROCESSOR_IDENTIFIER = 5'h05;
    localparam logic [4:0] CTL_RESERVED_SIX = 5'h06;
    localparam logic [4:0] CTL_EXCEPTION_CAUSE = 5'h07;
    localparam logic [4:0] CTL_PAGE_TABLE_ENTRY_ADDR = 5'h08;
    localparam logic [4:0] CTL_TLB_ENTRY_ACCESS = 5'h09;
    localparam logic [4:0] CTL_TLB_EXTRA_CONTROL = 5'h0a;
    localparam logic [4:0] CTL_ECC_ERROR_INJECT = 5'h0b;
    localparam logic [4:0] CTL_FAULTING_ADDRESS = 5'h0c;
    localparam logic [4:0] CTL_CORE_CONFIGURATION = 5'h0d;
    localparam logic [4:0] CTL_PROTECTION_REGION_BASE = 5'h0e;
    localparam logic [4:0] CTL_PROTECTION_REGION_ACCESS = 5'h0f;
    localparam logic [4:0] CTL_RESERVED_UPPER = 5'h10;
    // field positions and reset values
    localparam int STATUS_CRS_LSB = 10;
    localparam int CONFIG_MPU_ENABLE_BIT = 0;
    localparam logic [31:0] CTL_RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] CTL_DEFINED_MASK = 32'h0000_ffbf;
endpackage

// file: trap_source_model.sv
// model of the pipeline side that feeds trap and interrupt status words
`timescale 1ns/1ps
module trap_source_model (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // load request from the bench
    input wire logic load_in,
    input wire logic [31:0] value_in,
    // status words toward the register storage
    output logic [31:0] irq_pending_out,
    output logic [31:0] exception_cause_out,
    output logic [31:0] faulting_address_out
);
    always @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            irq_pending_out <= 32'h0000_0000;
            exception_cause_out <= 32'h0000_0000;
            faulting_address_out <= 32'h0000_0000;
        end
        else if (load_in)
        begin
            irq_pending_out <= value_in;
            exception_cause_out <= {value_in[15:0], value_in[31:16]};
            faulting_address_out <= ~value_in;
        end
    end
endmodule

// file: cpu_register_file_ctl_map_tb_top.sv
// self-checking bench for the register storage
`timescale 1ns/1ps
module cpu_register_file_ctl_map_tb_top;
    import regfile_pkg::*;
    localparam logic [31:0] ID = 32'h0000_0a5a; // arbitrary
    logic mclk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, dbg = 1'b0, sup = 1'b0;
    logic ctl_rd = 1'b0, ctl_wr = 1'b0, ld = 1'b0, valid, mpu_en;
    logic [0:0] rd_set = 1'h0, wr_set = 1'h0, cur_set;
    logic [4:0] ia = 5'h00, ib = 5'h00, wi = 5'h00, ci = 5'h00;
    logic [31:0] wd = 32'h0, cd = 32'h0, lv = 32'h0, da, db, crd, ip, ec, fa;
    int fails = 0, samples_checked = 0;
    int ents[$];
    always #2 mclk = ~mclk;
    cpu_register_file_ctl_map #(.CPU_ID_VALUE(ID)) cpu_register_file_ctl_map_inst (
        .mclk_in(mclk), .rst_n_in(rst_n), .rd_set_in(rd_set), .rd_a_idx_in(ia),
        .rd_b_idx_in(ib), .rd_a_data_out(da), .rd_b_data_out(db), .wr_en_in(wr_en),
        .wr_set_in(wr_set), .wr_idx_in(wi), .wr_data_in(wd), .wr_from_debug_in(dbg),
        .supervisor_mode_in(sup), .ctl_rd_en_in(ctl_rd), .ctl_wr_en_in(ctl_wr),
        .ctl_idx_in(ci), .ctl_wr_data_in(cd), .ctl_rd_data_out(crd),
        .ctl_rd_valid_out(valid), .irq_pending_in(ip), .exception_cause_in(ec),
        .faulting_address_in(fa), .mpu_enable_out(mpu_en), .current_set_out(cur_set));
    trap_source_model trap_source_model_inst (.mclk_in(mclk), .rst_n_in(rst_n),
        .load_in(ld), .value_in(lv), .irq_pending_out(ip), .exception_cause_out(ec),
        .faulting_address_out(fa));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic gw(input logic [0:0] s, input logic [4:0] i, input logic [31:0] d,
                      input logic g);
        @(posedge mclk);
        wr_en <= 1'b1;
        wr_set <= s;
        wi <= i;
        wd <= d;
        dbg <= g;
        @(posedge mclk);
        wr_en <= 1'b0;
        dbg <= 1'b0;
    endtask
    task automatic gr(input logic [0:0] s, input logic [4:0] a, input logic [4:0] b,
                      input logic [31:0] ea, input logic [31:0] eb);
        @(posedge mclk);
        rd_set <= s;
        ia <= a;
        ib <= b;
        @(posedge mclk);
        #1;
        check(da, ea);
        check(db, eb);
    endtask
    task automatic cw(input logic s, input logic [4:0] i, input logic [31:0] d);
        @(posedge mclk);
        ctl_wr <= 1'b1;
        sup <= s;
        ci <= i;
        cd <= d;
        @(posedge mclk);
        ctl_wr <= 1'b0;
    endtask
    task automatic cr(input logic s, input logic [4:0] i, input logic [31:0] e);
        @(posedge mclk);
        ctl_rd <= 1'b1;
        sup <= s;
        ci <= i;
        @(posedge mclk);
        ctl_rd <= 1'b0;
        #1;
        check(crd, e);
        check({31'h0, valid}, {31'h0, s});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        #40000;
        fails++;
        final_report();
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check({31'h0, mpu_en}, 32'h0);
        gw(1'h0, 5'h03, 32'hcafe_0003, 1'b0);
        gw(1'h0, 5'h00, 32'hffff_ffff, 1'b0);
        gr(1'h0, 5'h03, 5'h00, 32'hcafe_0003, ZERO_WORD);
        gw(1'h0, RETURN_ADDRESS_IDX, 32'h0000_1f1c, 1'b0);
        gw(1'h0, BREAKPOINT_TEMP_IDX, 32'h0000_0b25, 1'b1);
        gw(1'h0, BREAKPOINT_TEMP_IDX, 32'hdead_0025, 1'b0);
        gr(1'h0, RETURN_ADDRESS_IDX, BREAKPOINT_TEMP_IDX, 32'h0000_1f1c, 32'h0000_0b25);
        $display("test general registers done");
        gw(1'h1, SHADOW_STATUS_IDX, 32'h0000_5151, 1'b0);
        gw(1'h0, SHADOW_STATUS_IDX, 32'h0000_0ba0, 1'b0);
        gr(1'h1, SHADOW_STATUS_IDX, 5'h00, 32'h0000_5151, ZERO_WORD);
        gr(1'h0, SHADOW_STATUS_IDX, 5'h03, 32'h0000_0ba0, 32'hcafe_0003);
        $display("test shadow set done");
        // software leaves undefined bits zero; regions 14 and 15 set before enable
        ents = '{1, 2, 3, 9, 11, 14, 15};
        foreach (ents[k])
        begin
            cw(1'b1, ents[k][4:0], 32'h0000_0001);
            cr(1'b1, ents[k][4:0], 32'h0000_0001);
        end
        ents = '{6, 16, 31, 5};
        foreach (ents[k])
        begin
            cw(1'b1, ents[k][4:0], 32'hffff_ffff);
            cr(1'b1, ents[k][4:0], (k == 3) ? ID : ZERO_WORD);
        end
        $display("test control map done");
        cw(1'b0, CTL_IRQ_ENABLE_MASK, 32'h0000_0000);
        cr(1'b1, CTL_IRQ_ENABLE_MASK, 32'h0000_0001);
        cr(1'b0, CTL_IRQ_ENABLE_MASK, ZERO_WORD);
        @(posedge mclk);
        ld <= 1'b1;
        lv <= 32'h1234_5678;
        @(posedge mclk);
        ld <= 1'b0;
        cr(1'b1, CTL_IRQ_PENDING_BITS, 32'h1234_5678);
        cr(1'b1, CTL_EXCEPTION_CAUSE, 32'h5678_1234);
        cr(1'b1, CTL_FAULTING_ADDRESS, 32'hedcb_a987);
        $display("test supervisor access done");
        cw(1'b1, CTL_CORE_CONFIGURATION, 32'h0000_0001);
        #1;
        check({31'h0, mpu_en}, 32'h1);
        cw(1'b1, CTL_CORE_CONFIGURATION, 32'h0000_0000);
        #1;
        check({31'h0, mpu_en}, 32'h0);
        cw(1'b1, CTL_PROCESSOR_STATUS, 32'h0000_0400);
        #1;
        check({31'h0, cur_set}, 32'h1);
        cw(1'b1, CTL_PROCESSOR_STATUS, 32'h0000_0000);
        #1;
        check({31'h0, cur_set}, 32'h0);
        cw(1'b1, CTL_CORE_CONFIGURATION, 32'h0000_0001);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check({31'h0, mpu_en}, 32'h0);
        cr(1'b1, CTL_CORE_CONFIGURATION, ZERO_WORD);
        $display("test protection enable done");
        final_report();
    end
endmodule
